// file: inc/mfp_pkg.sv
// =====================================================================
// Shared constants and types of the motor fault protection block
// =====================================================================
package mfp_pkg;
   // Register byte offsets
   localparam logic [7:0] MFP_OFS_CTRL = 8'h00;
   localparam logic [7:0] MFP_OFS_SPEED = 8'h04;
   localparam logic [7:0] MFP_OFS_STATE = 8'h08;
   localparam logic [7:0] MFP_OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0] MFP_OFS_IRQ_EN = 8'h10;
   localparam logic [7:0] MFP_OFS_IRQ_CLR = 8'h14;
   // Control field positions
   localparam int MFP_CTRL_LOCK_PERIOD = 0;
   localparam int MFP_CTRL_OFF_PERIOD = 1;
   localparam int MFP_CTRL_STALL_DIS = 2;
   localparam int MFP_CTRL_THRESH = 3;
   localparam int MFP_CTRL_HYST_LO = 4;
   localparam int MFP_CTRL_FILT_LO = 6;
   localparam int MFP_CTRL_NATIVE150 = 8;
   localparam int MFP_CTRL_LATCH_MODE = 9;
   localparam int MFP_CTRL_WIDTH = 10;
   localparam logic [9:0] MFP_CTRL_RESET = 10'h000;
   localparam int MFP_SPEED_WIDTH = 10;
   localparam logic [9:0] MFP_SPEED_RESET = 10'h000;
   // Interrupt event bit positions
   localparam int MFP_EV_LOCK = 0;
   localparam int MFP_EV_HARD = 1;
   localparam int MFP_EV_LATCH = 2;
   localparam int MFP_EV_LIMIT = 3;
   localparam int MFP_EV_OVER = 4;
   localparam int MFP_EV_PUMP = 5;
   localparam int MFP_EV_THERM = 6;
   localparam int MFP_EV_NUM = 7;
   // Timing
   localparam int MFP_CLK_KHZ = 40000;
   localparam int MFP_LOCK_SHORT_MS = 300;
   localparam int MFP_LOCK_LONG_MS = 600;
   localparam int MFP_LOCK_SHORT_CYC = MFP_LOCK_SHORT_MS * MFP_CLK_KHZ;
   localparam int MFP_LOCK_LONG_CYC = MFP_LOCK_LONG_MS * MFP_CLK_KHZ;
   localparam logic [3:0] MFP_OFF_MULT_LONG = 4'ha;
   localparam logic [3:0] MFP_OFF_MULT_SHORT = 4'h5;
   localparam logic [3:0] MFP_FILT_BASE = 4'h5;
   localparam logic [2:0] MFP_EDGES_RELEASE = 3'h4;
   localparam logic [1:0] MFP_PWM_HOLD = 2'h2;
   localparam logic [3:0] MFP_RETRY_MAX = 4'h8;
   localparam logic [2:0] MFP_RATIO_FULL = 3'h0;
   // Supervisor states
   typedef enum logic [1:0] {
      MFP_RUN = 2'b00,
      MFP_OFF = 2'b01,
      MFP_LATCH = 2'b10
   } mfp_state_e;
   // APB request and answer
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } mfp_apb_req_s;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } mfp_apb_rsp_s;
endpackage

// file: rtl/mfp_top.sv
// What this block does
// - Hall silence times out, outputs off, retry
// - Period select picks 0.3 or 0.6 s
// - Off time is ten or five periods
// - Disable bit suppresses stall detection
// - Two rotations release stall; alarm meanwhile
// - Sine drive over threshold goes 150 degrees
// - Cut drive each PWM cycle at control
// - Two quiet PWM cycles restore sine drive
// - Native 150 mode: one level, always limit
// - Level and hysteresis selects steer references
// - Comparator filter of none, 6, 7, 8
// - Hard overcurrent: off, alarm, retry, release
// - Overvoltage forces 150 degrees without alarm
// - Eight retries latch off until speed reapplied
// - Hard filter one clock longer
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mfp_top #(
   parameter int LOCK_SHORT_CYC = mfp_pkg::MFP_LOCK_SHORT_CYC,
   parameter int LOCK_LONG_CYC = mfp_pkg::MFP_LOCK_LONG_CYC
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire mfp_pkg::mfp_apb_req_s apb_req,
   output mfp_pkg::mfp_apb_rsp_s apb_rsp,
   input wire logic hall_in,
   input wire logic pwm_cycle_start,
   input wire logic cmp_detect,
   input wire logic cmp_control,
   input wire logic cmp_hard,
   input wire logic overvoltage_guard,
   input wire logic supply_release,
   input wire logic supply_pump_low,
   input wire logic thermal_shutdown,
   output logic gate_enable,
   output logic drive_150,
   output logic pwm_terminate,
   output logic fault_alarm,
   output logic rotation_pulse_out,
   output logic rotation_pulse_oe,
   output logic limit_threshold_sel,
   output logic [2:0] limit_ratio_code,
   output logic irq
);
   import mfp_pkg::*;

   // ==================================================================
   // Declarations
   // ==================================================================
   logic [MFP_CTRL_WIDTH-1:0] ctrl_q; // Configuration bits
   logic [MFP_SPEED_WIDTH-1:0] speed_command; // Speed command word
   logic [MFP_EV_NUM-1:0] irq_stat_q; // Sticky events
   logic [MFP_EV_NUM-1:0] irq_en_q; // Event mask
   logic [MFP_EV_NUM-1:0] ev; // One-cycle event pulses
   logic [MFP_EV_NUM-1:0] clr_req; // Clear strobes from software
   mfp_state_e state_q; // Supervisor state
   logic hall_q; // Previous hall level
   logic hall_edge; // Zero crossing seen
   logic [24:0] lock_cnt_q; // Silence and off-time counter
   logic [24:0] lock_lim; // Selected period in cycles
   logic [3:0] off_mult_q; // Periods left in off time
   logic [3:0] off_mult; // Selected off multiple
   logic stall_q; // Stall fault pending release
   logic hard_q; // Hard fault pending release
   logic [3:0] retry_q; // Consecutive hard retries
   logic [2:0] rot_edges_q; // Edges since retry
   logic limit150_q; // 150 degrees by current limit
   logic over150_q; // 150 degrees by overvoltage
   logic [1:0] quiet_q; // PWM cycles without control hit
   logic hit_q; // Control hit in current PWM cycle
   logic [2:0] ov_edges_q; // Edges with supply released
   logic [3:0] need; // Filter length for the limit path
   logic [2:0] filt; // Filtered comparators
   logic [2:0] raw; // Raw comparators
   logic speed_zero; // No speed command
   logic speed_apply; // Speed command reapplied
   logic pump_q; // Previous pump flag
   logic therm_q; // Previous thermal flag
   logic stall_to; // Silence timeout this cycle
   logic hard_trip; // Hard overcurrent trip this cycle
   logic off_done; // Off time ends this cycle
   logic apb_wr; // Completed write
   logic sel_ctrl; // Address decodes
   logic sel_speed;
   logic sel_state;
   logic sel_stat;
   logic sel_en;
   logic sel_clr;
   logic mapped;

   // ==================================================================
   // APB slave
   // ==================================================================
   assign sel_ctrl = apb_req.paddr == MFP_OFS_CTRL;
   assign sel_speed = apb_req.paddr == MFP_OFS_SPEED;
   assign sel_state = apb_req.paddr == MFP_OFS_STATE;
   assign sel_stat = apb_req.paddr == MFP_OFS_IRQ_STAT;
   assign sel_en = apb_req.paddr == MFP_OFS_IRQ_EN;
   assign sel_clr = apb_req.paddr == MFP_OFS_IRQ_CLR;
   assign mapped = sel_ctrl | sel_speed | sel_state | sel_stat | sel_en | sel_clr;
   // Write lands only at the access edge that sees pready
   assign apb_wr = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite & mapped;
   assign clr_req = (apb_wr & sel_clr) ? apb_req.pwdata[MFP_EV_NUM-1:0] : '0;

   // Answer prepared in setup, shown for the one access cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         apb_rsp <= '0;
      end else if (apb_req.psel & ~apb_req.penable) begin
         apb_rsp.pready <= 1'b1;
         apb_rsp.pslverr <= ~mapped;
         apb_rsp.prdata <= '0;
         if (!apb_req.pwrite) begin
            // Read mux; write-only clear reads zero
            if (sel_ctrl) begin
               apb_rsp.prdata <= {22'h000000, ctrl_q};
            end else if (sel_speed) begin
               apb_rsp.prdata <= {22'h000000, speed_command};
            end else if (sel_state) begin
               apb_rsp.prdata <= {16'h0000, retry_q, 2'h0, state_q, 1'b0, over150_q,
                                  limit150_q, hard_q, stall_q, fault_alarm, gate_enable, drive_150};
            end else if (sel_stat) begin
               apb_rsp.prdata <= {25'h0000000, irq_stat_q};
            end else if (sel_en) begin
               apb_rsp.prdata <= {25'h0000000, irq_en_q};
            end
         end
      end else begin
         apb_rsp.pready <= 1'b0;
         apb_rsp.pslverr <= 1'b0;
      end
   end

   // Configuration and speed registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= MFP_CTRL_RESET;
         speed_command <= MFP_SPEED_RESET;
         irq_en_q <= '0;
      end else if (apb_wr) begin
         if (sel_ctrl) ctrl_q <= apb_req.pwdata[MFP_CTRL_WIDTH-1:0];
         if (sel_speed) speed_command <= apb_req.pwdata[MFP_SPEED_WIDTH-1:0];
         if (sel_en) irq_en_q <= apb_req.pwdata[MFP_EV_NUM-1:0];
      end
   end

   assign speed_zero = speed_command == '0;
   // Reapplied means a nonzero value written while the command was zero
   assign speed_apply = apb_wr & sel_speed & speed_zero & (apb_req.pwdata[MFP_SPEED_WIDTH-1:0] != '0);

   // ==================================================================
   // Interrupts
   // ==================================================================
   // Set beats clear so an event in the clear cycle survives
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_q <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~clr_req) | ev;
         irq <= |(((irq_stat_q & ~clr_req) | ev) & irq_en_q);
      end
   end

   // ==================================================================
   // Comparator filters
   // ==================================================================
   // Length 1 means no filter; else 6, 7 or 8 clocks
   assign need = (ctrl_q[MFP_CTRL_FILT_LO +: 2] == 2'b00) ? 4'h1 :
                 MFP_FILT_BASE + {2'b00, ctrl_q[MFP_CTRL_FILT_LO +: 2]};
   assign raw = {cmp_hard, cmp_control, cmp_detect};

   generate
      for (genvar i = 0; i < 3; i++) begin : g_filt
         logic [3:0] run_q; // Consecutive high clocks, saturating
         logic [3:0] len; // Needed run for this comparator
         // Hard path waits one clock more against pulse current
         assign len = (i == 2) ? need + 4'h1 : need;
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               run_q <= '0;
               filt[i] <= 1'b0;
            end else begin
               if (!raw[i]) begin
                  run_q <= '0;
               end else if (run_q != 4'hf) begin
                  run_q <= run_q + 4'h1;
               end
               filt[i] <= raw[i] && (({1'b0, run_q} + 5'h01) >= {1'b0, len});
            end
         end
      end
   endgenerate

   // ==================================================================
   // Hall edges and fault supervisor
   // ==================================================================
   assign hall_edge = hall_in ^ hall_q;
   assign lock_lim = ctrl_q[MFP_CTRL_LOCK_PERIOD] ? 25'(LOCK_LONG_CYC - 1) : 25'(LOCK_SHORT_CYC - 1);
   assign off_mult = ctrl_q[MFP_CTRL_OFF_PERIOD] ? MFP_OFF_MULT_SHORT : MFP_OFF_MULT_LONG;
   // Silence counts only while driving with a command; disable bit masks it
   assign stall_to = (state_q == MFP_RUN) && !speed_zero && !ctrl_q[MFP_CTRL_STALL_DIS] &&
                     !hall_edge && (lock_cnt_q == lock_lim);
   assign hard_trip = (state_q == MFP_RUN) && filt[2];
   assign off_done = (state_q == MFP_OFF) && (lock_cnt_q == lock_lim) && (off_mult_q == 4'h1);

   // Supervisor state and timing
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= MFP_RUN;
         lock_cnt_q <= '0;
         off_mult_q <= '0;
         hall_q <= 1'b0;
      end else begin
         hall_q <= hall_in;
         unique case (state_q)
            MFP_RUN: begin
               if (hard_trip && (ctrl_q[MFP_CTRL_LATCH_MODE] || retry_q == MFP_RETRY_MAX - 4'h1)) begin
                  state_q <= MFP_LATCH;
               end else if (hard_trip || stall_to) begin
                  state_q <= MFP_OFF;
                  lock_cnt_q <= '0;
                  off_mult_q <= off_mult;
               end else if (hall_edge || speed_zero) begin
                  lock_cnt_q <= '0;
               end else begin
                  lock_cnt_q <= lock_cnt_q + 25'h1;
               end
            end
            MFP_OFF: begin
               // Off time runs as whole lock periods
               if (off_done) begin
                  state_q <= MFP_RUN;
                  lock_cnt_q <= '0;
               end else if (lock_cnt_q == lock_lim) begin
                  lock_cnt_q <= '0;
                  off_mult_q <= off_mult_q - 4'h1;
               end else begin
                  lock_cnt_q <= lock_cnt_q + 25'h1;
               end
            end
            MFP_LATCH: begin
               if (speed_apply) begin
                  state_q <= MFP_RUN;
                  lock_cnt_q <= '0;
               end
            end
         endcase
      end
   end

   // Fault flags, retry count and release rotation count
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stall_q <= 1'b0;
         hard_q <= 1'b0;
         retry_q <= '0;
         rot_edges_q <= '0;
      end else begin
         if (stall_to) stall_q <= 1'b1;
         if (hard_trip) begin
            hard_q <= 1'b1;
            retry_q <= retry_q + 4'h1;
         end
         if (state_q != MFP_RUN || hard_trip || stall_to) begin
            rot_edges_q <= '0;
         end else if (hall_edge && (stall_q || hard_q)) begin
            if (rot_edges_q == MFP_EDGES_RELEASE - 3'h1) begin
               // Two rotations clean: release both
               stall_q <= 1'b0;
               hard_q <= 1'b0;
               retry_q <= '0;
               rot_edges_q <= '0;
            end else begin
               rot_edges_q <= rot_edges_q + 3'h1;
            end
         end
         if (state_q == MFP_LATCH && speed_apply) begin
            hard_q <= 1'b0;
            retry_q <= '0;
         end
      end
   end

   // ==================================================================
   // Current limit and overvoltage drive mode
   // ==================================================================
   // Sine mode leaves via detection or overvoltage
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         limit150_q <= 1'b0;
         quiet_q <= '0;
         hit_q <= 1'b0;
      end else begin
         if (ctrl_q[MFP_CTRL_NATIVE150]) begin
            limit150_q <= 1'b0;
            quiet_q <= '0;
         end else if (!limit150_q && !over150_q && filt[0]) begin
            limit150_q <= 1'b1;
            quiet_q <= '0;
         end else if (limit150_q && pwm_cycle_start) begin
            // Count whole PWM cycles without a control hit
            if (hit_q) begin
               quiet_q <= '0;
            end else if (quiet_q == MFP_PWM_HOLD - 2'h1) begin
               limit150_q <= 1'b0;
               quiet_q <= '0;
            end else begin
               quiet_q <= quiet_q + 2'h1;
            end
         end
         hit_q <= pwm_cycle_start ? 1'b0 : (hit_q | filt[1]);
      end
   end

   // Overvoltage hold, released by zero command or clean rotations
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         over150_q <= 1'b0;
         ov_edges_q <= '0;
      end else if (ctrl_q[MFP_CTRL_NATIVE150]) begin
         over150_q <= 1'b0;
         ov_edges_q <= '0;
      end else if (!over150_q) begin
         over150_q <= overvoltage_guard && !limit150_q && !speed_zero;
         ov_edges_q <= '0;
      end else if (speed_zero) begin
         over150_q <= 1'b0;
      end else if (!supply_release) begin
         ov_edges_q <= '0;
      end else if (hall_edge) begin
         if (ov_edges_q == MFP_EDGES_RELEASE - 3'h1) begin
            over150_q <= 1'b0;
         end
         ov_edges_q <= ov_edges_q + 3'h1;
      end
   end

   // ==================================================================
   // Registered outputs
   // ==================================================================
   // Gates, mode, cut, alarm and rotation pin
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gate_enable <= 1'b0;
         drive_150 <= 1'b0;
         pwm_terminate <= 1'b0;
         fault_alarm <= 1'b0;
         rotation_pulse_out <= 1'b0;
         rotation_pulse_oe <= 1'b0;
      end else begin
         gate_enable <= (state_q == MFP_RUN) && !hard_trip && !stall_to &&
                        !supply_pump_low && !thermal_shutdown;
         drive_150 <= ctrl_q[MFP_CTRL_NATIVE150] | limit150_q | over150_q;
         // Cut to end of cycle once control level reached; detect level in native 150 mode
         if (pwm_cycle_start) begin
            pwm_terminate <= 1'b0;
         end else if (ctrl_q[MFP_CTRL_NATIVE150] ? filt[0] : (limit150_q & filt[1])) begin
            pwm_terminate <= 1'b1;
         end
         // Overvoltage deliberately stays off the alarm
         fault_alarm <= stall_q | hard_q | (state_q == MFP_LATCH) |
                        supply_pump_low | thermal_shutdown;
         rotation_pulse_out <= hall_in;
         rotation_pulse_oe <= (state_q == MFP_RUN) && !stall_to && !hard_trip;
      end
   end

   // Reference selects for the analog comparators
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         limit_threshold_sel <= 1'b0;
         limit_ratio_code <= MFP_RATIO_FULL;
      end else begin
         limit_threshold_sel <= ctrl_q[MFP_CTRL_THRESH];
         // Code 0 is full level; 1..4 are 0.95 down to 0.80
         limit_ratio_code <= ctrl_q[MFP_CTRL_NATIVE150] ? MFP_RATIO_FULL :
                             {1'b0, ctrl_q[MFP_CTRL_HYST_LO +: 2]} + 3'h1;
      end
   end

   // Event pulses for interrupts
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pump_q <= 1'b0;
         therm_q <= 1'b0;
      end else begin
         pump_q <= supply_pump_low;
         therm_q <= thermal_shutdown;
      end
   end
   assign ev[MFP_EV_LOCK] = stall_to;
   assign ev[MFP_EV_HARD] = hard_trip;
   assign ev[MFP_EV_LATCH] = hard_trip & (ctrl_q[MFP_CTRL_LATCH_MODE] | (retry_q == MFP_RETRY_MAX - 4'h1));
   assign ev[MFP_EV_LIMIT] = !ctrl_q[MFP_CTRL_NATIVE150] & !limit150_q & !over150_q & filt[0];
   assign ev[MFP_EV_OVER] = !ctrl_q[MFP_CTRL_NATIVE150] & !over150_q & !limit150_q & overvoltage_guard & !speed_zero;
   assign ev[MFP_EV_PUMP] = supply_pump_low & ~pump_q;
   assign ev[MFP_EV_THERM] = thermal_shutdown & ~therm_q;
endmodule // mfp_top
`default_nettype wire

// file: tb/mfp_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checks of the protection block
module mfp_checker (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire mfp_pkg::mfp_apb_req_s apb_req,
   input wire mfp_pkg::mfp_apb_rsp_s apb_rsp,
   input wire logic hall_in,
   input wire logic supply_pump_low,
   input wire logic thermal_shutdown,
   input wire logic gate_enable,
   input wire logic fault_alarm,
   input wire logic rotation_pulse_out,
   input wire logic rotation_pulse_oe
);
   import mfp_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Setup cycle of a bus transfer
   sequence apb_setup;
      apb_req.psel && !apb_req.penable;
   endsequence
   // Either hard supply fault present
   sequence hot;
      thermal_shutdown || supply_pump_low;
   endsequence
   setup_ready_a: assert property (apb_setup |=> apb_rsp.pready) else $error("no pready after setup");
   ready_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
   err_data_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("bad error answer");
   hot_off_a: assert property (hot |=> !gate_enable && fault_alarm) else $error("gates on in fault");
   hot_hold_a: assert property (hot ##1 hot |-> !gate_enable) else $error("gates on held fault");
   gate_rise_a: assert property ($rose(gate_enable) |-> !$past(thermal_shutdown) && !$past(supply_pump_low))
      else $error("gates back in fault");
   oe_drop_a: assert property ($fell(rotation_pulse_oe) |-> !gate_enable) else $error("pulse pin off early");
   pulse_copy_a: assert property (rotation_pulse_oe |-> rotation_pulse_out == $past(hall_in))
      else $error("pulse pin not hall copy");
endmodule // mfp_checker
bind mfp_top mfp_checker chk (.sys_clk(sys_clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .hall_in(hall_in), .supply_pump_low(supply_pump_low), .thermal_shutdown(thermal_shutdown),
   .gate_enable(gate_enable), .fault_alarm(fault_alarm), .rotation_pulse_out(rotation_pulse_out),
   .rotation_pulse_oe(rotation_pulse_oe));
`default_nettype wire

// file: tb/mfp_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bridge, rotor and Hall sensor stand-in
module mfp_motor_model (
   input wire logic sys_clk,
   input wire logic gate_enable,
   input wire logic spin,
   output logic hall_in,
   output logic pwm_cycle_start
);
   logic [3:0] cnt_q; // Free PWM timebase
   initial begin
      hall_in = 1'b0;
      pwm_cycle_start = 1'b0;
      cnt_q = 4'h0;
   end
   // Rotor turns only while driven; a stalled rotor keeps its Hall level
   always @(posedge sys_clk) begin
      cnt_q <= cnt_q + 4'h1;
      pwm_cycle_start <= (cnt_q == 4'hf);
      if (spin && gate_enable && cnt_q[1:0] == 2'b11) begin
         hall_in <= !hall_in;
      end
   end
endmodule // mfp_motor_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Self-checking bench
module tb;
   import mfp_pkg::*;
   logic sys_clk, nrst, spin, det, ctl, hard, ovg, pump, therm, err, rel;
   logic gate, d150, term, alarm, rpo, rpoe, thr, irq;
   logic [2:0] ratio;
   logic [31:0] rd;
   wire logic hall, pwm_start;
   mfp_apb_req_s req;
   mfp_apb_rsp_s rsp;
   int miscompares = 0, checks_done = 0;
   mfp_top #(.LOCK_SHORT_CYC(10), .LOCK_LONG_CYC(20)) dut (.sys_clk(sys_clk), .nrst(nrst), .apb_req(req),
      .apb_rsp(rsp), .hall_in(hall), .pwm_cycle_start(pwm_start), .cmp_detect(det), .cmp_control(ctl),
      .cmp_hard(hard), .overvoltage_guard(ovg), .supply_release(rel), .supply_pump_low(pump),
      .thermal_shutdown(therm), .gate_enable(gate), .drive_150(d150), .pwm_terminate(term),
      .fault_alarm(alarm), .rotation_pulse_out(rpo), .rotation_pulse_oe(rpoe), .limit_threshold_sel(thr),
      .limit_ratio_code(ratio), .irq(irq));
   mfp_motor_model motor (.sys_clk(sys_clk), .gate_enable(gate), .spin(spin), .hall_in(hall),
      .pwm_cycle_start(pwm_start));
   // ==========
   // Shared helpers
   task automatic complete_run;
      if (miscompares == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // One transfer; waits for pready, then one idle edge so no strobe is set twice
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge sys_clk);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic gate_wait(input logic v, output int n);
      n = 0;
      while (gate !== v && n < 1000) begin
         @(posedge sys_clk);
         n++;
      end
   endtask
   // ==========
   // Scenarios
   task automatic stall_case(input logic [1:0] sel);
      int n, p, t;
      p = sel[0] ? 20 : 10;
      t = p * (sel[1] ? 5 : 10);
      apb(1'b1, MFP_OFS_CTRL, {30'h0, sel});
      spin <= 1'b0;
      gate_wait(1'b0, n);
      chk(n >= p - 3 && n <= p + 4, "stall timeout");
      cyc(1);
      chk(rpoe === 1'b0 && alarm === 1'b1, "stall off state");
      spin <= 1'b1;
      gate_wait(1'b1, n);
      chk(n >= t - 1 && n <= t + 1, "off time");
      cyc(24);
      chk(alarm === 1'b0 && gate === 1'b1, "stall release");
   endtask
   task automatic flags_case;
      apb(1'b1, MFP_OFS_CTRL, 32'h4);
      spin <= 1'b0;
      cyc(60);
      chk(gate === 1'b1 && alarm === 1'b0, "stall disabled");
      apb(1'b1, MFP_OFS_IRQ_EN, 32'h40);
      therm <= 1'b1;
      cyc(3);
      chk(gate === 1'b0 && alarm === 1'b1 && irq === 1'b1, "thermal");
      apb(1'b1, MFP_OFS_IRQ_CLR, 32'h40);
      cyc(1);
      chk(irq === 1'b0, "irq clear");
      therm <= 1'b0;
      pump <= 1'b1;
      cyc(3);
      chk(gate === 1'b0 && irq === 1'b0, "pump masked");
      apb(1'b0, MFP_OFS_IRQ_STAT, 32'h0);
      chk(rd[6:5] === 2'b01, "sticky status");
      pump <= 1'b0;
      spin <= 1'b1;
      apb(1'b1, MFP_OFS_IRQ_CLR, 32'h20);
   endtask
   task automatic limit_case;
      int n, k;
      for (int h = 0; h < 4; h++) begin
         apb(1'b1, MFP_OFS_CTRL, {26'h0, 2'(h), 4'hc});
         cyc(1);
         chk(thr === 1'b1 && ratio === 3'(h + 1), "ratio code");
      end
      apb(1'b1, MFP_OFS_CTRL, 32'h6c);
      det <= 1'b1;
      cyc(5);
      det <= 1'b0;
      cyc(4);
      chk(d150 === 1'b0, "short detect");
      det <= 1'b1;
      cyc(6);
      det <= 1'b0;
      ctl <= 1'b1;
      cyc(8);
      n = term;
      cyc(1);
      chk(d150 === 1'b1 && (n == 1 || term === 1'b1), "limit entry");
      ctl <= 1'b0;
      n = 0;
      k = 0;
      while (d150 !== 1'b0 && k < 200) begin
         @(posedge sys_clk);
         k++;
         if (pwm_start === 1'b1) n++;
      end
      chk(n >= 2 && n <= 3 && term === 1'b0, "sine return");
      apb(1'b1, MFP_OFS_CTRL, 32'h16c);
      cyc(2);
      chk(d150 === 1'b1 && ratio === 3'h0, "native mode");
      det <= 1'b1;
      cyc(8);
      n = term;
      cyc(1);
      det <= 1'b0;
      chk(n == 1 || term === 1'b1, "native cut");
   endtask
   task automatic hard_case;
      apb(1'b1, MFP_OFS_CTRL, 32'h4);
      hard <= 1'b1;
      cyc(1000);
      hard <= 1'b0;
      apb(1'b0, MFP_OFS_STATE, 32'h0);
      chk(gate === 1'b0 && rd[9:8] === 2'h2 && rd[15:12] === 4'h8, "retry latch");
      apb(1'b1, MFP_OFS_SPEED, 32'h0);
      apb(1'b1, MFP_OFS_SPEED, 32'h1);
      apb(1'b1, MFP_OFS_CTRL, 32'h204);
      hard <= 1'b1;
      cyc(1);
      hard <= 1'b0;
      cyc(4);
      chk(gate === 1'b1, "hard glitch");
      hard <= 1'b1;
      cyc(2);
      hard <= 1'b0;
      cyc(3);
      chk(gate === 1'b0 && alarm === 1'b1, "hard trip");
      cyc(250);
      chk(gate === 1'b0, "latched off");
      apb(1'b1, MFP_OFS_SPEED, 32'h0);
      apb(1'b1, MFP_OFS_SPEED, 32'h1);
      cyc(3);
      chk(gate === 1'b1, "latch cleared");
      ovg <= 1'b1;
      cyc(3);
      chk(d150 === 1'b1 && alarm === 1'b0, "overvoltage entry");
      ovg <= 1'b0;
      rel <= 1'b1;
      cyc(24);
      chk(d150 === 1'b0, "overvoltage release");
      rel <= 1'b0;
      ovg <= 1'b1;
      cyc(3);
      ovg <= 1'b0;
      chk(d150 === 1'b1, "overvoltage again");
      apb(1'b1, MFP_OFS_SPEED, 32'h0);
      cyc(2);
      chk(d150 === 1'b0, "overvoltage exit");
   endtask
   // ==========
   // Clock, watchdog and main sequence
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      #(25 * 20000);
      miscompares++;
      complete_run;
   end
   initial begin
      {nrst, spin, det, ctl, hard, ovg, pump, therm, rel} = '0;
      req = '0;
      cyc(10);
      nrst <= 1'b1;
      cyc(1);
      apb(1'b0, MFP_OFS_CTRL, 32'h0);
      chk(rd === 32'h0, "ctrl reset");
      apb(1'b0, 8'h20, 32'h0);
      chk(err === 1'b1 && rd === 32'h0, "unmapped");
      spin <= 1'b1;
      apb(1'b1, MFP_OFS_SPEED, 32'h1);
      for (int s = 0; s < 4; s++) stall_case(2'(s));
      flags_case;
      limit_case;
      hard_case;
      complete_run;
   end
endmodule // tb
`default_nettype wire
